// ===== verilog/lism_pkg.sv
/*
 Constants for the interrupt status and mask register pair:
 offsets, reset values and bit positions.
 Assumes bit 0 of each register is its most significant bit.
*/
`default_nettype none

package lism_pkg;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] MASK_OFS = 8'h10;

    // Reset values
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h8000_0000;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // Positions that hold an event flag
    localparam logic [31:0] EVENT_BITS = 32'h7cfe_0000;

    // Bit n sits at vector position 31 - n
    localparam int SUM_POS = 31;
    localparam int PHY_IRQ_POS = 30;
    localparam int BUS_RST_POS = 29;
    localparam int CMD_RST_POS = 28;
    localparam int SELF_ID_POS = 27;
    localparam int PHY_PKT_POS = 26;
    localparam int BUSY_ACK_POS = 23;
    localparam int PHY_REG_POS = 22;
    localparam int FIFO_ACC_POS = 21;
    localparam int HDR_CRC_POS = 20;
    localparam int TCODE_POS = 19;
    localparam int CYC_SEC_POS = 18;
    localparam int CYC_START_POS = 17;

endpackage

`default_nettype wire

// ===== verilog/lism_core.sv
/*
 Interrupt status and mask registers behind an APB slave.
 Event strobes come from logic on the same clock, one cycle high
 per event. Drives an active-low interrupt pin.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module lism_core (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event strobes
    input wire logic phy_irq_set,
    input wire logic bus_reset_set,
    input wire logic cmd_reset_set,
    input wire logic self_id_end_set,
    input wire logic phy_pkt_set,
    input wire logic busy_ack_set,
    input wire logic phy_reg_set,
    input wire logic fifo_access_set,
    input wire logic header_crc_set,
    input wire logic bad_tcode_set,
    input wire logic cycle_second_set,
    input wire logic cycle_start_set,
    // Interrupt
    output logic irq_summary,
    output logic irq_out_n
);

    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] prdata_r;
    logic err_r;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] be_v;
    logic [31:0] rd_v;
    logic st_hit;
    logic mk_hit;
    logic miss;
    logic setup;
    logic wr_go;
    logic summary;
    logic cap_r;
    logic take;

    // Named views of the flags
    logic phy_irq_flag;
    logic cmd_reset_rx_flag;
    logic busy_ack_sent_flag;
    logic phy_reg_rx_flag;
    logic bad_fifo_access_flag;
    logic header_crc_flag;
    logic bad_tcode_flag;
    logic cycle_second_flag;

    assign phy_irq_flag = status_r[lism_pkg::PHY_IRQ_POS];
    assign cmd_reset_rx_flag = status_r[lism_pkg::CMD_RST_POS];
    assign busy_ack_sent_flag = status_r[lism_pkg::BUSY_ACK_POS];
    assign phy_reg_rx_flag = status_r[lism_pkg::PHY_REG_POS];
    assign bad_fifo_access_flag = status_r[lism_pkg::FIFO_ACC_POS];
    assign header_crc_flag = status_r[lism_pkg::HDR_CRC_POS];
    assign bad_tcode_flag = status_r[lism_pkg::TCODE_POS];
    assign cycle_second_flag = status_r[lism_pkg::CYC_SEC_POS];

    // Event strobes onto their positions
    always_comb begin
        set_v = 32'h0000_0000;
        set_v[lism_pkg::PHY_IRQ_POS] = phy_irq_set;
        set_v[lism_pkg::BUS_RST_POS] = bus_reset_set;
        set_v[lism_pkg::CMD_RST_POS] = cmd_reset_set;
        set_v[lism_pkg::SELF_ID_POS] = self_id_end_set;
        set_v[lism_pkg::PHY_PKT_POS] = phy_pkt_set;
        set_v[lism_pkg::BUSY_ACK_POS] = busy_ack_set;
        set_v[lism_pkg::PHY_REG_POS] = phy_reg_set;
        set_v[lism_pkg::FIFO_ACC_POS] = fifo_access_set;
        set_v[lism_pkg::HDR_CRC_POS] = header_crc_set;
        set_v[lism_pkg::TCODE_POS] = bad_tcode_set;
        set_v[lism_pkg::CYC_SEC_POS] = cycle_second_set;
        set_v[lism_pkg::CYC_START_POS] = cycle_start_set;
    end

    // Byte strobes widened to bits
    genvar gi;
    generate
        for (gi = 0; gi < lism_pkg::STRB_W; gi++) begin : g_be
            assign be_v[8*gi +: 8] = {8{pstrb[gi]}};
        end
    endgenerate

    // Address decode
    always_comb begin
        st_hit = 1'b0;
        mk_hit = 1'b0;
        miss = 1'b0;
        if (paddr == lism_pkg::STATUS_OFS) begin
            st_hit = 1'b1;
        end else if (paddr == lism_pkg::MASK_OFS) begin
            mk_hit = 1'b1;
        end else begin
            miss = 1'b1;
        end
    end

    // Bus phases
    assign setup = psel & ~penable;
    assign take = clk_en & psel & ~cap_r;
    assign pready = psel & penable & clk_en & cap_r;
    assign wr_go = pready & pwrite;
    assign pslverr = pready & err_r;
    assign prdata = prdata_r;

    // Write-one-to-clear, event flag positions only
    assign clr_v = (wr_go & st_hit) ?
        (pwdata & be_v & lism_pkg::EVENT_BITS) : 32'h0000_0000;

    // Set wins over a clear in the same cycle
    assign status_nxt = ((status_r & ~clr_v) | set_v)
        & lism_pkg::EVENT_BITS;

    // Masked bits take no part in the summary
    assign summary = |(status_r & mask_r
        & lism_pkg::EVENT_BITS);
    assign irq_summary = summary;
    assign irq_out_n = ~summary;

    // Status flags; no bus-reset clear path exists
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            status_r <= lism_pkg::STATUS_RST;
        end else if (clk_en) begin
            status_r <= status_nxt;
        end
    end

    // Mask, byte-lane writes
    assign mask_nxt = (mask_r & ~be_v) | (pwdata & be_v);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mask_r <= lism_pkg::MASK_RST;
        end else if (clk_en && wr_go && mk_hit) begin
            mask_r <= mask_nxt;
        end
    end

    // Read data with the summary in the top position
    always_comb begin
        rd_v = 32'h0000_0000;
        if (st_hit) begin
            rd_v = status_r;
            rd_v[lism_pkg::SUM_POS] = summary;
        end else if (mk_hit) begin
            rd_v = mask_r;
        end
    end

    // Capture flag: a setup cycle with enable low still gets its data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cap_r <= 1'b0;
        end else if (pready) begin
            cap_r <= 1'b0;
        end else if (take) begin
            cap_r <= 1'b1;
        end
    end

    // Read data and error caught once per transfer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_r <= lism_pkg::PRDATA_RST;
        end else if (take) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_v;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_r <= 1'b0;
        end else if (take) begin
            err_r <= miss;
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    status_reset_a: assert property (
        disable iff (1'b0) !rst_n |=> status_r == 32'h0000_0000)
        else $error("status not zero after reset");

    mask_reset_a: assert property (
        disable iff (1'b0) !rst_n |=> mask_r == 32'h8000_0000)
        else $error("mask not 8000_0000 after reset");

    bus_reset_keep_a: assert property (
        clk_en && bus_reset_set && !wr_go |=>
        ((status_r & $past(status_r)) == $past(status_r))
        && mask_r == $past(mask_r))
        else $error("bus reset disturbed the registers");

    masked_quiet_a: assert property (
        clk_en && !wr_go && (set_v & mask_r) == 32'h0000_0000
        && (status_r & mask_r & lism_pkg::EVENT_BITS) == 32'h0
        |=> irq_out_n)
        else $error("masked bit raised the interrupt");

    masked_set_a: assert property (
        clk_en && phy_irq_set && !mask_r[lism_pkg::PHY_IRQ_POS]
        && !wr_go && (set_v & mask_r) == 32'h0000_0000
        |=> phy_irq_flag && irq_out_n == $past(irq_out_n))
        else $error("masked event not held or leaked");

    summary_read_a: assert property (
        clk_en && setup && st_hit && !pwrite |=>
        prdata[31] == $past(summary))
        else $error("read summary bit wrong");

    pin_follow_a: assert property (
        clk_en && phy_reg_set && mask_r[lism_pkg::PHY_REG_POS]
        |=> !irq_out_n && irq_summary)
        else $error("enabled event did not drive pin low");

    ev_phy_irq_a: assert property (
        clk_en && phy_irq_set |=> phy_irq_flag)
        else $error("phy irq flag not set");

    ev_bus_rst_a: assert property (
        clk_en && bus_reset_set |=> status_r[lism_pkg::BUS_RST_POS])
        else $error("bus reset flag not set");

    ev_cmd_rst_a: assert property (
        clk_en && cmd_reset_set |=> cmd_reset_rx_flag)
        else $error("command reset flag not set");

    ev_self_id_a: assert property (
        clk_en && self_id_end_set |=> status_r[lism_pkg::SELF_ID_POS])
        else $error("self id end flag not set");

    ev_phy_pkt_a: assert property (
        clk_en && phy_pkt_set |=> status_r[lism_pkg::PHY_PKT_POS])
        else $error("phy packet flag not set");

    ev_busy_ack_a: assert property (
        clk_en && busy_ack_set |=> busy_ack_sent_flag)
        else $error("busy ack flag not set");

    ev_phy_reg_a: assert property (
        clk_en && phy_reg_set |=> phy_reg_rx_flag)
        else $error("phy register flag not set");

    ev_fifo_acc_a: assert property (
        clk_en && fifo_access_set |=> bad_fifo_access_flag)
        else $error("fifo access flag not set");

    ev_hdr_crc_a: assert property (
        clk_en && header_crc_set |=> header_crc_flag)
        else $error("header crc flag not set");

    ev_tcode_a: assert property (
        clk_en && bad_tcode_set |=> bad_tcode_flag)
        else $error("tcode flag not set");

    ev_cyc_sec_a: assert property (
        clk_en && cycle_second_set |=> cycle_second_flag)
        else $error("cycle second flag not set");

    ev_cyc_start_a: assert property (
        clk_en && cycle_start_set |=>
        status_r[lism_pkg::CYC_START_POS])
        else $error("cycle start flag not set");

    clear_one_a: assert property (
        clk_en && wr_go && st_hit && set_v == 32'h0000_0000 |=>
        (status_r & $past(pwdata) & $past(be_v)) == 32'h0000_0000)
        else $error("write one did not clear");

    set_wins_a: assert property (
        clk_en && set_v != 32'h0000_0000 |=>
        (status_r & $past(set_v)) == $past(set_v))
        else $error("clear beat a set");

    hold_flags_a: assert property (
        clk_en && set_v == 32'h0000_0000 && !(wr_go && st_hit)
        |=> status_r == $past(status_r))
        else $error("flags changed without cause");

    bit_order_a: assert property (
        (status_r & ~lism_pkg::EVENT_BITS) == 32'h0000_0000)
        else $error("flag outside event positions");

    freeze_a: assert property (
        !clk_en |=> status_r == $past(status_r)
        && mask_r == $past(mask_r))
        else $error("state moved with enable low");

    ready_phase_a: assert property (
        pready |-> psel && penable && $past(psel))
        else $error("pready outside access phase");

    unmapped_err_a: assert property (
        clk_en && setup && miss ##1 pready |-> pslverr)
        else $error("unmapped access not refused");

    mask_write_a: assert property (
        wr_go && mk_hit |=> mask_r == (($past(mask_r) & ~$past(be_v))
        | ($past(pwdata) & $past(be_v))))
        else $error("mask write did not land");

    mask_keep_a: assert property (
        !(wr_go && mk_hit) |=> mask_r == $past(mask_r))
        else $error("mask moved without a write");

    read_status_a: assert property (
        take && st_hit && !pwrite |=>
        (prdata & 32'h7fff_ffff) == $past(status_r))
        else $error("status read data wrong");

    read_mask_a: assert property (
        take && mk_hit && !pwrite |=> prdata == $past(mask_r))
        else $error("mask read data wrong");

    unmapped_read_a: assert property (
        take && miss |=> prdata == 32'h0000_0000 && err_r)
        else $error("unmapped read not zero");

    stall_ready_a: assert property (
        !clk_en |-> !pready)
        else $error("pready high with enable low");

    one_capture_a: assert property (
        cap_r |-> psel)
        else $error("capture flag outside a transfer");

    pin_inverse_a: assert property (
        irq_out_n == !irq_summary)
        else $error("pin not inverse of summary");

endmodule // lism_core

`default_nettype wire

// ===== sim/lism_host.sv
/*
 Host side model: an APB master that performs one transfer per call.
 Assumes a single clock shared with the slave and a zero or more
 cycle answer signalled by pready.
*/
`timescale 1ns/10ps
`default_nettype none

module lism_host (
    // Clock
    input wire logic clock,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // Setup, then access held until pready seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // lism_host

`default_nettype wire

// ===== sim/tb.sv
/*
 Testbench for the interrupt status and mask pair.
 Assumes the host model for APB cycles and drives event strobes itself.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clock, rst_n, clk_en, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic pready, pslverr, irq_summary, irq_out_n, rerr;
    logic [11:0] ev;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    lism_core u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phy_irq_set(ev[0]), .bus_reset_set(ev[1]),
        .cmd_reset_set(ev[2]), .self_id_end_set(ev[3]),
        .phy_pkt_set(ev[4]), .busy_ack_set(ev[5]), .phy_reg_set(ev[6]),
        .fifo_access_set(ev[7]), .header_crc_set(ev[8]),
        .bad_tcode_set(ev[9]), .cycle_second_set(ev[10]),
        .cycle_start_set(ev[11]), .irq_summary(irq_summary),
        .irq_out_n(irq_out_n));

    lism_host u_host (.clock(clock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic er);
        u_host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rdat, rerr);
        chk("prdata", exp, rdat);
        chk("pslverr", {31'h0, er}, {31'h0, rerr});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        u_host.xfer(1'b1, a, d, s, rdat, rerr);
    endtask

    // Let the edge's updates land before looking at the pin
    task automatic pin(input logic exp);
        #1;
        chk("irq_out_n", {31'h0, exp}, {31'h0, irq_out_n});
        chk("irq_summary", {31'h0, ~exp}, {31'h0, irq_summary});
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
    endtask

    // One event: set, read, pin low, clear, pin high, read cleared
    task automatic ev_case(input int i, input int p);
        pulse(i);
        rd(lism_pkg::STATUS_OFS, (32'h1 << p) | 32'h8000_0000, 1'b0);
        pin(1'b0);
        wr(lism_pkg::STATUS_OFS, 32'h1 << p, 4'hf);
        pin(1'b1);
        rd(lism_pkg::STATUS_OFS, lism_pkg::STATUS_RST, 1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        ev = 12'h000;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(lism_pkg::STATUS_OFS, lism_pkg::STATUS_RST, 1'b0);
        rd(lism_pkg::MASK_OFS, lism_pkg::MASK_RST, 1'b0);
        pin(1'b1);
        $display("test reset_values done");
        wr(lism_pkg::MASK_OFS, 32'hffff_ffff, 4'hf);
        rd(lism_pkg::MASK_OFS, 32'hffff_ffff, 1'b0);
        ev_case(0, 30);
        ev_case(1, 29);
        ev_case(2, 28);
        ev_case(3, 27);
        ev_case(4, 26);
        ev_case(5, 23);
        ev_case(6, 22);
        ev_case(7, 21);
        ev_case(8, 20);
        ev_case(9, 19);
        ev_case(10, 18);
        ev_case(11, 17);
        $display("test each_event done");
        wr(lism_pkg::MASK_OFS, lism_pkg::MASK_RST, 4'hf);
        pulse(0);
        pulse(1);
        rd(lism_pkg::STATUS_OFS, 32'h6000_0000, 1'b0);
        rd(lism_pkg::MASK_OFS, lism_pkg::MASK_RST, 1'b0);
        pin(1'b1);
        wr(lism_pkg::STATUS_OFS, 32'h0000_0000, 4'hf);
        wr(lism_pkg::STATUS_OFS, 32'h2000_0000, 4'h7);
        rd(lism_pkg::STATUS_OFS, 32'h6000_0000, 1'b0);
        wr(lism_pkg::MASK_OFS, 32'h2000_0000, 4'hf);
        rd(lism_pkg::STATUS_OFS, 32'he000_0000, 1'b0);
        pin(1'b0);
        wr(lism_pkg::STATUS_OFS, 32'h6000_0000, 4'hf);
        rd(lism_pkg::STATUS_OFS, lism_pkg::STATUS_RST, 1'b0);
        pin(1'b1);
        $display("test masked_events done");
        fork
            rd(8'h14, 32'h0000_0000, 1'b1);
            begin
                repeat (2) @(posedge clock);
                clk_en <= 1'b0;
                repeat (3) @(posedge clock);
                clk_en <= 1'b1;
            end
        join
        wr(8'h14, 32'hffff_ffff, 4'hf);
        rd(lism_pkg::MASK_OFS, 32'h2000_0000, 1'b0);
        // Enable low across the setup cycle: data must still be fresh
        fork
            rd(lism_pkg::STATUS_OFS, lism_pkg::STATUS_RST, 1'b0);
            begin
                @(posedge clock);
                clk_en <= 1'b0;
                repeat (2) @(posedge clock);
                clk_en <= 1'b1;
            end
        join
        $display("test unmapped_and_wait done");
        pulse(2);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(lism_pkg::STATUS_OFS, lism_pkg::STATUS_RST, 1'b0);
        rd(lism_pkg::MASK_OFS, lism_pkg::MASK_RST, 1'b0);
        pin(1'b1);
        $display("test mid_reset done");
        summarize();
    end
endmodule // tb

`default_nettype wire
